// >>> bspl_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef BSPL_REGS_SVH
`define BSPL_REGS_SVH

`define BSPL_OFS_EVENT      12'h004
`define BSPL_OFS_FAULT      12'h008
`define BSPL_OFS_STATUS     12'h00c
`define BSPL_OFS_MASK       12'h010
`define BSPL_OFS_PGCFG      12'h020
`define BSPL_OFS_DISCFG     12'h024
`define BSPL_OFS_SLEWCFG    12'h038
`define BSPL_OFS_VREF       12'h040
`define BSPL_OFS_IREF       12'h044

`define BSPL_BIT_MODE_EVT   7
`define BSPL_BIT_OC_FLAG    6
`define BSPL_BIT_OV_FLAG    5
`define BSPL_BIT_CC_STAT    4
`define BSPL_BIT_WIN_STAT   2
`define BSPL_BIT_PG_DLY_LO  6
`define BSPL_BIT_DIS_EN     5
`define BSPL_BIT_SLEW_LO    2

`define BSPL_RST_MASK       8'h00
`define BSPL_RST_PGCFG      8'h00
`define BSPL_RST_DISCFG     8'h00
`define BSPL_RST_SLEWCFG    8'h00
`define BSPL_RST_VREF       16'h0000
`define BSPL_RST_IREF       8'h00

`define BSPL_OCP_PAIRS      3'd4
`define BSPL_PG_DLY0        12'd0
`define BSPL_PG_DLY1        12'd64
`define BSPL_PG_DLY2        12'd512
`define BSPL_PG_DLY3        12'd2048

`endif

// >>> bspl_pkg.sv
// types shared by the protection logic
`default_nettype none
package bspl_pkg;
    typedef enum logic [1:0] {
        BSPL_OFF,
        BSPL_SERVO,
        BSPL_ON,
        BSPL_LATCHED
    } bspl_state_t;

    typedef enum logic [1:0] {
        BSPL_CBC_IDLE,
        BSPL_CBC_FORCE
    } bspl_cbc_t;
endpackage : bspl_pkg
`default_nettype wire

// >>> bspl_delay.sv
// programmable delay line for the power-good level
`include "bspl_regs.svh"
`default_nettype none
module bspl_delay
    import bspl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] sel,
    input  wire logic       din,
    output var  logic       dout
);
    logic [11:0] cnt_reg;
    logic [11:0] cnt_next;
    logic        out_reg;
    logic        out_next;
    logic [11:0] limit;

    function automatic logic [11:0] dly_of(input logic [1:0] s);
        case (s)
            2'd0:    dly_of = `BSPL_PG_DLY0;
            2'd1:    dly_of = `BSPL_PG_DLY1;
            2'd2:    dly_of = `BSPL_PG_DLY2;
            default: dly_of = `BSPL_PG_DLY3;
        endcase
    endfunction : dly_of

    assign limit = dly_of(sel);

    // a rising decision waits the selected count; a falling one passes at once
    // so that a short low spell always restarts the full delay
    always_comb begin
        cnt_next = cnt_reg;
        out_next = out_reg;
        if (!din) begin
            out_next = 1'b0;
            cnt_next = 12'h000;
        end else if (out_reg) begin
            cnt_next = 12'h000;
        end else if (cnt_reg >= limit) begin
            out_next = 1'b1;
            cnt_next = 12'h000;
        end else begin
            cnt_next = cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 12'h000;
            out_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule : bspl_delay
`default_nettype wire

// >>> bspl_top.sv
// status, power-good and protection logic of the main converter
//
// Contract
// - cc/cv change sets event bit, interrupts
// - mode status high in cc, low cv
// - power-good high only in on state
// - servo activity forces power-good low
// - any reference servo blanks power-good
// - status bit shows output inside window
// - two-bit field selects power-good delay
// - accept new references while enabled
// - discharge resistor on lowering voltage reference
// - two-bit field selects switch slew
// - high limit forces low until low limit
// - limit overrides regulation gate commands
// - continuous limit reports constant current
// - four limit pairs trigger over-current
// - over-current sets fault flag
// - over-voltage sets fault flag
// - faults latch off until enable low
//
// Our own choices: the APB register port and the register addresses.
`include "bspl_regs.svh"
`default_nettype none
module bspl_top
    import bspl_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ,
    input  wire logic        ENABLE_IN,
    input  wire logic        CC_LOOP_ACTIVE,
    input  wire logic        ABOVE_WINDOW_UPPER,
    input  wire logic        BELOW_WINDOW_LOWER,
    input  wire logic        ABOVE_OVP_THRESHOLD,
    input  wire logic        HS_OVER_UPPER_LIMIT,
    input  wire logic        LS_OVER_LOWER_LIMIT,
    input  wire logic        OUTPUT_ABOVE_VREF,
    input  wire logic        SERVO_DONE,
    input  wire logic        REG_HS_ON,
    input  wire logic        REG_LS_ON,
    output logic             HS_GATE,
    output logic             LS_GATE,
    output logic             CONVERTER_RUN,
    output logic             SERVO_START,
    output logic      [15:0] VREF_TARGET,
    output logic      [7:0]  IREF_TARGET,
    output logic             DISCHARGE_ON,
    output logic      [1:0]  SLEW_SELECT,
    input  wire logic        POWER_GOOD_IN,
    output logic             POWER_GOOD_OUT,
    output logic             POWER_GOOD_OE_N
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change taken when stages two and three agree
    logic [2:0] sy_en, sy_cc, sy_hi, sy_lo, sy_ov, sy_hs, sy_ls, sy_ab;
    logic       en_reg, cc_reg, hi_reg, lo_reg, ov_reg, hs_reg, ls_reg, ab_reg;

    function automatic logic agree(input logic [2:0] s, input logic cur);
        agree = (s[1] == s[2]) ? s[2] : cur;
    endfunction : agree

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            sy_en <= 3'h0; sy_cc <= 3'h0; sy_hi <= 3'h0; sy_lo <= 3'h0;
            sy_ov <= 3'h0; sy_hs <= 3'h0; sy_ls <= 3'h0; sy_ab <= 3'h0;
            en_reg <= 1'b0; cc_reg <= 1'b0; hi_reg <= 1'b0; lo_reg <= 1'b0;
            ov_reg <= 1'b0; hs_reg <= 1'b0; ls_reg <= 1'b0; ab_reg <= 1'b0;
        end else begin
            sy_en <= {sy_en[1:0], ENABLE_IN};
            sy_cc <= {sy_cc[1:0], CC_LOOP_ACTIVE};
            sy_hi <= {sy_hi[1:0], ABOVE_WINDOW_UPPER};
            sy_lo <= {sy_lo[1:0], BELOW_WINDOW_LOWER};
            sy_ov <= {sy_ov[1:0], ABOVE_OVP_THRESHOLD};
            sy_hs <= {sy_hs[1:0], HS_OVER_UPPER_LIMIT};
            sy_ls <= {sy_ls[1:0], LS_OVER_LOWER_LIMIT};
            sy_ab <= {sy_ab[1:0], OUTPUT_ABOVE_VREF};
            en_reg <= agree(sy_en, en_reg);
            cc_reg <= agree(sy_cc, cc_reg);
            hi_reg <= agree(sy_hi, hi_reg);
            lo_reg <= agree(sy_lo, lo_reg);
            ov_reg <= agree(sy_ov, ov_reg);
            hs_reg <= agree(sy_hs, hs_reg);
            ls_reg <= agree(sy_ls, ls_reg);
            ab_reg <= agree(sy_ab, ab_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb register file
    logic [7:0]  mask_reg, mask_next;
    logic [7:0]  pgcfg_reg, pgcfg_next;
    logic [7:0]  discfg_reg, discfg_next;
    logic [7:0]  slewcfg_reg, slewcfg_next;
    logic [15:0] vref_reg, vref_next;
    logic [7:0]  iref_reg, iref_next;
    logic [7:0]  event_reg, event_next;
    logic [7:0]  fault_reg, fault_next;
    logic        ref_wr;
    logic        wr_en;
    logic [7:0]  status_word;
    logic        mode_evt, oc_evt, ov_evt;

    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;

    always_comb begin
        mask_next    = mask_reg;
        pgcfg_next   = pgcfg_reg;
        discfg_next  = discfg_reg;
        slewcfg_next = slewcfg_reg;
        vref_next    = vref_reg;
        iref_next    = iref_reg;
        ref_wr       = 1'b0;
        event_next   = event_reg;
        fault_next   = fault_reg;
        if (wr_en) begin
            if (PADDR == `BSPL_OFS_EVENT) begin
                event_next = event_reg & ~PWDATA[7:0];
            end else if (PADDR == `BSPL_OFS_FAULT) begin
                fault_next = fault_reg & ~PWDATA[7:0];
            end else if (PADDR == `BSPL_OFS_MASK) begin
                mask_next = PWDATA[7:0];
            end else if (PADDR == `BSPL_OFS_PGCFG) begin
                pgcfg_next = PWDATA[7:0];
            end else if (PADDR == `BSPL_OFS_DISCFG) begin
                discfg_next = PWDATA[7:0];
            end else if (PADDR == `BSPL_OFS_SLEWCFG) begin
                slewcfg_next = PWDATA[7:0];
            end else if (PADDR == `BSPL_OFS_VREF) begin
                vref_next = PWDATA[15:0];
                ref_wr    = 1'b1;
            end else if (PADDR == `BSPL_OFS_IREF) begin
                iref_next = PWDATA[7:0];
                ref_wr    = 1'b1;
            end
        end
        // set wins over a clear in the same cycle
        if (mode_evt) event_next[`BSPL_BIT_MODE_EVT] = 1'b1;
        if (oc_evt) fault_next[`BSPL_BIT_OC_FLAG] = 1'b1;
        if (ov_evt) fault_next[`BSPL_BIT_OV_FLAG] = 1'b1;
    end

    always_comb begin
        PRDATA = 32'h0000_0000;
        if (PADDR == `BSPL_OFS_EVENT) begin
            PRDATA[7:0] = event_reg;
        end else if (PADDR == `BSPL_OFS_FAULT) begin
            PRDATA[7:0] = fault_reg;
        end else if (PADDR == `BSPL_OFS_STATUS) begin
            PRDATA[7:0] = status_word;
        end else if (PADDR == `BSPL_OFS_MASK) begin
            PRDATA[7:0] = mask_reg;
        end else if (PADDR == `BSPL_OFS_PGCFG) begin
            PRDATA[7:0] = pgcfg_reg;
        end else if (PADDR == `BSPL_OFS_DISCFG) begin
            PRDATA[7:0] = discfg_reg;
        end else if (PADDR == `BSPL_OFS_SLEWCFG) begin
            PRDATA[7:0] = slewcfg_reg;
        end else if (PADDR == `BSPL_OFS_VREF) begin
            PRDATA[15:0] = vref_reg;
        end else if (PADDR == `BSPL_OFS_IREF) begin
            PRDATA[7:0] = iref_reg;
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            mask_reg    <= `BSPL_RST_MASK;
            pgcfg_reg   <= `BSPL_RST_PGCFG;
            discfg_reg  <= `BSPL_RST_DISCFG;
            slewcfg_reg <= `BSPL_RST_SLEWCFG;
            vref_reg    <= `BSPL_RST_VREF;
            iref_reg    <= `BSPL_RST_IREF;
            event_reg   <= 8'h00;
            fault_reg   <= 8'h00;
        end else begin
            mask_reg    <= mask_next;
            pgcfg_reg   <= pgcfg_next;
            discfg_reg  <= discfg_next;
            slewcfg_reg <= slewcfg_next;
            vref_reg    <= vref_next;
            iref_reg    <= iref_next;
            event_reg   <= event_next;
            fault_reg   <= fault_next;
        end
    end

    assign IRQ = |((event_reg | fault_reg) & mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // cycle-by-cycle limit and over-current pair counter
    bspl_cbc_t cbc_reg, cbc_next;
    logic [2:0] pair_reg, pair_next;
    logic       cbc_cont_reg, cbc_cont_next;

    always_comb begin
        cbc_next      = cbc_reg;
        pair_next     = pair_reg;
        cbc_cont_next = cbc_cont_reg;
        oc_evt        = 1'b0;
        case (cbc_reg)
            BSPL_CBC_IDLE: begin
                if (hs_reg) begin
                    cbc_next = BSPL_CBC_FORCE;
                end else if (REG_HS_ON) begin
                    // a regular cycle without a limit breaks the run
                    pair_next     = 3'd0;
                    cbc_cont_next = 1'b0;
                end
            end
            default: begin
                if (!ls_reg) begin
                    cbc_next = BSPL_CBC_IDLE;
                    if (pair_reg + 3'd1 >= `BSPL_OCP_PAIRS) begin
                        oc_evt    = 1'b1;
                        pair_next = 3'd0;
                    end else begin
                        pair_next = pair_reg + 3'd1;
                    end
                    cbc_cont_next = (pair_reg != 3'd0);
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            cbc_reg      <= BSPL_CBC_IDLE;
            pair_reg     <= 3'd0;
            cbc_cont_reg <= 1'b0;
        end else begin
            cbc_reg      <= cbc_next;
            pair_reg     <= pair_next;
            cbc_cont_reg <= cbc_cont_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // converter state, servo and protection latch
    bspl_state_t st_reg, st_next;
    logic        cc_mode_reg, cc_mode_next;
    logic        hs_out, ls_out;

    assign ov_evt = ov_reg;

    always_comb begin
        st_next     = st_reg;
        SERVO_START = 1'b0;
        case (st_reg)
            BSPL_OFF: begin
                if (en_reg) begin
                    st_next     = BSPL_SERVO;
                    SERVO_START = 1'b1;
                end
            end
            BSPL_SERVO: begin
                if (SERVO_DONE && !ref_wr) st_next = BSPL_ON;
            end
            BSPL_ON: begin
                if (ref_wr) begin
                    st_next     = BSPL_SERVO;
                    SERVO_START = 1'b1;
                end
            end
            default: begin
                if (!en_reg) st_next = BSPL_OFF;
            end
        endcase
        if (st_reg == BSPL_SERVO && ref_wr) SERVO_START = 1'b1;
        if (st_reg != BSPL_LATCHED) begin
            if (oc_evt || ov_evt) begin
                st_next     = BSPL_LATCHED;
                SERVO_START = 1'b0;
            end else if (!en_reg) begin
                st_next     = BSPL_OFF;
                SERVO_START = 1'b0;
            end
        end
    end

    always_comb begin
        cc_mode_next = cc_reg || cbc_cont_reg;
        mode_evt     = (cc_mode_next != cc_mode_reg);
        hs_out       = 1'b0;
        ls_out       = 1'b0;
        if (st_reg == BSPL_ON || st_reg == BSPL_SERVO) begin
            if (cbc_reg == BSPL_CBC_FORCE) begin
                ls_out = 1'b1;
            end else begin
                hs_out = REG_HS_ON;
                ls_out = REG_LS_ON && !REG_HS_ON;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            st_reg      <= BSPL_OFF;
            cc_mode_reg <= 1'b0;
            HS_GATE     <= 1'b0;
            LS_GATE     <= 1'b0;
        end else begin
            st_reg      <= st_next;
            cc_mode_reg <= cc_mode_next;
            HS_GATE     <= hs_out;
            LS_GATE     <= ls_out;
        end
    end

    assign status_word = {3'b000, cc_mode_reg, 1'b0,
                          !hi_reg && !lo_reg, 2'b00};

    assign CONVERTER_RUN = (st_reg == BSPL_ON) || (st_reg == BSPL_SERVO);
    assign VREF_TARGET   = vref_reg;
    assign IREF_TARGET   = iref_reg;
    assign SLEW_SELECT   = slewcfg_reg[`BSPL_BIT_SLEW_LO +: 2];
    assign DISCHARGE_ON  = discfg_reg[`BSPL_BIT_DIS_EN] && ab_reg &&
                           (st_reg == BSPL_SERVO);

    ////////////////////////////////////////////////////////////////////////////
    // power-good: only in the on state, blanked during any servo move
    logic pg_raw;
    logic pg_dly;

    assign pg_raw = (st_reg == BSPL_ON);

    bspl_delay u_pg_delay (
        .clk  (REF_CLK),
        .rst  (RESET),
        .sel  (pgcfg_reg[`BSPL_BIT_PG_DLY_LO +: 2]),
        .din  (pg_raw),
        .dout (pg_dly)
    );

    // open drain: enable low pulls the pin low; released otherwise
    assign POWER_GOOD_OUT  = 1'b0;
    assign POWER_GOOD_OE_N = pg_dly && pg_raw;

    logic unused_pg_in;
    assign unused_pg_in = POWER_GOOD_IN;
endmodule : bspl_top
`default_nettype wire

// >>> bspl_top_assertions.sv
// concurrent checks on the protection block ports
`default_nettype none
module bspl_chk (
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        IRQ,
    input wire logic        ENABLE_IN,
    input wire logic        REG_HS_ON,
    input wire logic        HS_GATE,
    input wire logic        LS_GATE,
    input wire logic        CONVERTER_RUN,
    input wire logic        SERVO_START,
    input wire logic [15:0] VREF_TARGET,
    input wire logic [1:0]  SLEW_SELECT,
    input wire logic        POWER_GOOD_OE_N
);
    logic [1:0]  wd_slew;
    logic [15:0] wd_vref;
    assign wd_slew = PWDATA[3:2];
    assign wd_vref = PWDATA[15:0];
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_wr(a);
        PSEL && PENABLE && PWRITE && PADDR == a;
    endsequence
    property p_pg_off;
        !CONVERTER_RUN [*3] |-> !POWER_GOOD_OE_N;
    endproperty
    a_pg_off: assert property (p_pg_off) else $error("pg up while stopped");
    property p_servo_pg;
        SERVO_START |=> !POWER_GOOD_OE_N;
    endproperty
    a_servo_pg: assert property (p_servo_pg) else $error("pg up in servo");
    property p_gates;
        !(HS_GATE && LS_GATE);
    endproperty
    a_gates: assert property (p_gates) else $error("both gates on");
    property p_hs_cmd;
        HS_GATE |-> $past(REG_HS_ON);
    endproperty
    a_hs_cmd: assert property (p_hs_cmd) else $error("hs without command");
    property p_slew;
        s_wr(12'h038) |=> SLEW_SELECT == $past(wd_slew);
    endproperty
    a_slew: assert property (p_slew) else $error("slew not taken");
    property p_vref;
        s_wr(12'h040) ##0 CONVERTER_RUN |=> VREF_TARGET == $past(wd_vref);
    endproperty
    a_vref: assert property (p_vref) else $error("vref not taken");
    property p_irq_hold;
        IRQ && !(PSEL && PENABLE && PWRITE) |=> IRQ;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_en_off;
        !ENABLE_IN [*6] |-> !CONVERTER_RUN;
    endproperty
    a_en_off: assert property (p_en_off) else $error("runs while disabled");
endmodule : bspl_chk
`default_nettype wire

// >>> bspl_pg_host.sv
// power-good pin with its pull-up, as the host sees it
`default_nettype none
module bspl_pg_host (
    input  wire logic oe_n,
    input  wire logic drv,
    output var  logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // released pin floats up to the pull-up level
    always_comb pin = oe_n ? 1'h1 : drv;
endmodule : bspl_pg_host
`default_nettype wire

// >>> bspl_top_tb_top.sv
// self-checking bench for the protection block
`include "bspl_regs.svh"
`default_nettype none
module bspl_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, psel, pen, pwr, en, cc, whi, wlo, ov, hso, lso, abv, sd, rhs, rls;
    logic        prdy, perr, irq, hsg, lsg, run, ss, dis, pgo, oen, pg;
    logic [11:0] pa;
    logic [31:0] pwd, prd, q;
    logic [15:0] vt;
    logic [7:0]  it;
    logic [1:0]  sl;
    int          n_fail, compares, k;
    bspl_top dut (.REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .IRQ(irq),
        .ENABLE_IN(en), .CC_LOOP_ACTIVE(cc), .ABOVE_WINDOW_UPPER(whi),
        .BELOW_WINDOW_LOWER(wlo), .ABOVE_OVP_THRESHOLD(ov), .HS_OVER_UPPER_LIMIT(hso),
        .LS_OVER_LOWER_LIMIT(lso), .OUTPUT_ABOVE_VREF(abv), .SERVO_DONE(sd), .REG_HS_ON(rhs),
        .REG_LS_ON(rls), .HS_GATE(hsg), .LS_GATE(lsg), .CONVERTER_RUN(run), .SERVO_START(ss),
        .VREF_TARGET(vt), .IREF_TARGET(it), .DISCHARGE_ON(dis), .SLEW_SELECT(sl),
        .POWER_GOOD_IN(pg), .POWER_GOOD_OUT(pgo), .POWER_GOOD_OE_N(oen));
    bspl_pg_host host (.oe_n(oen), .drv(pgo), .pin(pg));
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'h1 && n < 16);
        if (n >= 16) n_fail++;
        q = prd;
        psel <= 1'h0;
        pen  <= 1'h0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(nm, q & m, exp);
    endtask : rd
    task automatic start_up();
        for (k = 0; k < 20 && ss !== 1'h1; k++) @(posedge clk);
        chk("servo start", 32'(ss), 32'h1);
        cyc(2);
        chk("pg servo", 32'(pg), 32'h0);
    endtask : start_up
    task automatic done();
        sd <= 1'h1;
        @(posedge clk);
        sd <= 1'h0;
    endtask : done
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end
    initial begin
        rst = 1'h1;
        {psel, pen, pwr, en, cc, whi, wlo, ov, hso, lso, abv, sd, rhs, rls, pa, pwd} = '0;
        n_fail = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rd("mask rst", `BSPL_OFS_MASK, 32'hff, 32'(`BSPL_RST_MASK));
        chk("pg rst", 32'(pg), 32'h0);
        apb(1'h1, `BSPL_OFS_MASK, 32'he0);
        en <= 1'h1;
        start_up();
        done();
        cyc(4);
        chk("pg on", 32'(pg), 32'h1);
        $display("test start-up done");
        apb(1'h1, `BSPL_OFS_PGCFG, 32'h40);
        apb(1'h1, `BSPL_OFS_IREF, 32'h80);
        chk("pg iref", 32'(pg), 32'h0);
        chk("iref", 32'(it), 32'h80);
        done();
        cyc(`BSPL_PG_DLY1 - 8);
        chk("pg delayed", 32'(pg), 32'h0);
        cyc(16);
        chk("pg late", 32'(pg), 32'h1);
        apb(1'h1, `BSPL_OFS_PGCFG, 32'h0);
        $display("test pg delay done");
        for (int s = 0; s < 4; s++) begin
            apb(1'h1, `BSPL_OFS_SLEWCFG, 32'(s) << 2);
            chk("slew", 32'(sl), 32'(s));
        end
        abv <= 1'h1;
        apb(1'h1, `BSPL_OFS_DISCFG, 32'h20);
        apb(1'h1, `BSPL_OFS_VREF, 32'h0100);
        chk("discharge", 32'(dis), 32'h1);
        chk("vref", 32'(vt), 32'h100);
        abv <= 1'h0;
        done();
        cyc(6);
        chk("discharge off", 32'(dis), 32'h0);
        $display("test references done");
        cc <= 1'h1;
        cyc(8);
        rd("cc stat", `BSPL_OFS_STATUS, 32'h10, 32'h10);
        rd("mode evt", `BSPL_OFS_EVENT, 32'h80, 32'h80);
        chk("irq evt", 32'(irq), 32'h1);
        cc <= 1'h0;
        cyc(8);
        rd("cv stat", `BSPL_OFS_STATUS, 32'h10, 32'h0);
        chk("irq sticky", 32'(irq), 32'h1);
        apb(1'h1, `BSPL_OFS_EVENT, 32'h80);
        rd("evt clr", `BSPL_OFS_EVENT, 32'h80, 32'h0);
        chk("irq clr", 32'(irq), 32'h0);
        for (int i = 0; i < 3; i++) begin
            whi <= (i == 1);
            wlo <= (i == 2);
            cyc(8);
            rd("window", `BSPL_OFS_STATUS, 32'h4, (i == 0) ? 32'h4 : 32'h0);
        end
        wlo <= 1'h0;
        $display("test status done");
        for (int i = 0; i < 4; i++) begin
            hso <= 1'h1;
            lso <= 1'h1;
            cyc(6);
            rhs <= 1'h1;
            cyc(2);
            chk("hs forced", 32'(hsg), 32'h0);
            rhs <= 1'h0;
            hso <= 1'h0;
            cyc(3);
            chk("ls held", 32'(lsg), 32'h1);
            lso <= 1'h0;
            cyc(8);
            chk("ls freed", 32'(lsg), 32'h0);
            if (i == 1) rd("cbc cc", `BSPL_OFS_STATUS, 32'h10, 32'h10);
            if (i == 2) rd("no oc", `BSPL_OFS_FAULT, 32'h40, 32'h0);
        end
        cyc(4);
        rd("oc fault", `BSPL_OFS_FAULT, 32'h60, 32'h40);
        chk("oc irq", 32'(irq), 32'h1);
        cyc(20);
        chk("latched", 32'(run), 32'h0);
        chk("pg latched", 32'(pg), 32'h0);
        en <= 1'h0;
        cyc(8);
        en <= 1'h1;
        start_up();
        done();
        rhs <= 1'h1;
        cyc(4);
        chk("restart", 32'(run), 32'h1);
        chk("hs regular", 32'(hsg), 32'h1);
        rhs <= 1'h0;
        apb(1'h1, `BSPL_OFS_FAULT, 32'h60);
        $display("test current limit done");
        ov <= 1'h1;
        cyc(8);
        rd("ov fault", `BSPL_OFS_FAULT, 32'h60, 32'h20);
        chk("ov latched", 32'(run), 32'h0);
        ov <= 1'h0;
        cyc(6);
        chk("ov stays", 32'(run), 32'h0);
        apb(1'h1, `BSPL_OFS_FAULT, 32'h60);
        rd("fault clr", `BSPL_OFS_FAULT, 32'h60, 32'h0);
        rd("unmapped", 12'h0fc, 32'hffffffff, 32'h0);
        chk("slverr", 32'(perr), 32'h0);
        $display("test over-voltage done");
        results();
    end
endmodule : bspl_top_tb_top
bind bspl_top bspl_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .IRQ(IRQ),
    .ENABLE_IN(ENABLE_IN), .REG_HS_ON(REG_HS_ON), .HS_GATE(HS_GATE), .LS_GATE(LS_GATE),
    .CONVERTER_RUN(CONVERTER_RUN), .SERVO_START(SERVO_START), .VREF_TARGET(VREF_TARGET),
    .SLEW_SELECT(SLEW_SELECT), .POWER_GOOD_OE_N(POWER_GOOD_OE_N));
`default_nettype wire
